//--- hw/bc_rate_divider.sv
// Back-channel bit-rate enable generator.
// Assumes rate is a registered code from the mode register block.
module bc_rate_divider
   import rx_link_mode_pkg::*;
(
   input  wire logic core_clk,
   input  wire logic resetn,
   bc_rate_if.gen    bcRate
);

   logic [3:0] divCnt_r;
   logic [1:0] lastRate_r;
   logic       tick_r;

   assign bcRate.tick = tick_r;

   // A new rate reloads at once, so no stretched bit mixes two rates
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         divCnt_r   <= 4'h0;
         lastRate_r <= RATE_5M;
         tick_r     <= 1'b0;
      end else if (bcRate.rate != lastRate_r) begin
         lastRate_r <= bcRate.rate;
         divCnt_r   <= rateDivisor(bcRate.rate) - 4'h1;
         tick_r     <= 1'b0;
      end else if (divCnt_r == 4'h0) begin
         divCnt_r <= rateDivisor(bcRate.rate) - 4'h1;
         tick_r   <= 1'b1;
      end else begin
         divCnt_r <= divCnt_r - 4'h1;
         tick_r   <= 1'b0;
      end
   end

endmodule

//--- hw/bc_rate_if.sv
// Carries the selected back-channel rate to the bit-clock divider.
// Assumes both ends run on the core clock.
interface bc_rate_if;
   logic [1:0] rate;
   logic       tick;
   modport ctl (output rate, input tick);
   modport gen (input rate, output tick);
endinterface

//--- hw/receiver_link_mode_register.sv
// Receiver link mode register: back-channel rate, cable type, automatic
// audio format and repeater strap status, with strap load after reset.
// Assumes a one-cycle register port on core_clk and an asynchronous strap pin.
//
// Implementation choices: the address map and the strobed register port.

// Notes on behaviour
// - Fast clear: select 0 is 5M, 1 is 10M
// - Fast set: 20M, select ignored
// - Rate change flags a brief error window
// - Auto audio takes mode from aux codes, resets 1
// - Cable bit: 0 twisted pair, 1 coax
// - Fast bit loads from strap, stays writable
// - Cable bit loads from strap, stays writable
// - Read-only repeater flag from strap
// - Register answers at offset 0x23
module receiver_link_mode_register
   import rx_link_mode_pkg::*;
(
   input  wire logic       core_clk,
   input  wire logic       resetn,
   input  wire logic [7:0] regAddr,
   input  wire logic [7:0] regWrData,
   input  wire logic       regWrEn,
   input  wire logic       regRdEn,
   output logic      [7:0] regRdData,
   input  wire logic [2:0] strapConfigPinOne,
   input  wire logic       auxCodeValid,
   input  wire logic [1:0] auxAudioCode,
   input  wire logic [1:0] manualAudioMode,
   output logic      [1:0] backChannelRate,
   output logic            backChannelTick,
   output logic            backChannelSettling,
   output logic            cableCoax,
   output logic            autoAudioEn,
   output logic      [1:0] audioMode,
   output logic            repeaterStrapped,
   output logic            strapLoaded
);

   typedef enum logic {ST_SETTLE, ST_RUN} strap_state_type;

   strap_state_type strapState_r;

   logic [2:0] strapSync1_r;
   logic [2:0] strapSync2_r;
   logic [2:0] strapSync3_r;
   logic [1:0] strapWait_r;
   logic       strapStable;
   logic       strapLoadNow;

   logic       rateSel_r;
   logic       fast_r;
   logic       autoAudio_r;
   logic       coax_r;
   logic       repeater_r;
   logic       loaded_r;
   logic [7:0] rdData_r;
   logic       wrHit;
   logic       rdHit;
   logic [7:0] modeValue;

   logic [1:0] rate_r;
   logic [1:0] rateNxt;
   logic [7:0] settleCnt_r;
   logic       settling_r;
   logic [1:0] audioMode_r;

   bc_rate_if bcRate ();

   // Strap pin crossing: three flops, the first feeds only the second
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         strapSync1_r <= 3'h0;
         strapSync2_r <= 3'h0;
         strapSync3_r <= 3'h0;
      end else begin
         strapSync1_r <= strapConfigPinOne;
         strapSync2_r <= strapSync1_r;
         strapSync3_r <= strapSync2_r;
      end
   end

   assign strapStable  = (strapSync2_r == strapSync3_r);
   assign strapLoadNow = (strapState_r == ST_SETTLE) &&
                         (strapWait_r == STRAP_WAIT_CYC) && strapStable;

   // Wait until the pin has really reached the third flop before loading
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         strapState_r <= ST_SETTLE;
         strapWait_r  <= 2'h0;
         loaded_r     <= 1'b0;
      end else begin
         case (strapState_r)
            ST_SETTLE: begin
               if (strapWait_r != STRAP_WAIT_CYC)
                  strapWait_r <= strapWait_r + 2'h1;
               if (strapLoadNow) begin
                  strapState_r <= ST_RUN;
                  loaded_r     <= 1'b1;
               end
            end
            ST_RUN: begin
               loaded_r <= 1'b1;
            end
            default: begin
               strapState_r <= ST_SETTLE;
               strapWait_r  <= 2'h0;
               loaded_r     <= 1'b0;
            end
         endcase
      end
   end

   // Writes before the strap load would be lost to it, so they are refused
   assign wrHit = regWrEn && (regAddr == MODE_REG_OFFSET) && loaded_r;
   assign rdHit = regRdEn && (regAddr == MODE_REG_OFFSET);

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         rateSel_r   <= RST_RATE_SEL;
         autoAudio_r <= RST_AUTO_AUDIO;
      end else if (wrHit) begin
         rateSel_r   <= regWrData[BIT_RATE_SEL];
         autoAudio_r <= regWrData[BIT_AUTO_AUDIO];
      end
   end

   // Fast and cable bits: strap at load time, software afterwards
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         fast_r <= RST_FAST;
         coax_r <= RST_COAX;
      end else if (strapLoadNow) begin
         fast_r <= strapSync3_r[STRAP_FAST];
         coax_r <= strapSync3_r[STRAP_COAX];
      end else if (wrHit) begin
         fast_r <= regWrData[BIT_FAST];
         coax_r <= regWrData[BIT_COAX];
      end
   end

   // Repeater flag only ever comes from the strap
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn)
         repeater_r <= RST_REPEATER;
      else if (strapLoadNow)
         repeater_r <= strapSync3_r[STRAP_REPEATER];
   end

   always_comb begin
      modeValue                 = 8'h00;
      modeValue[BIT_RATE_SEL]   = rateSel_r;
      modeValue[BIT_AUTO_AUDIO] = autoAudio_r;
      modeValue[BIT_FAST]       = fast_r;
      modeValue[BIT_COAX]       = coax_r;
      modeValue[BIT_REPEATER]   = repeater_r;
   end

   // Read data stands for one cycle only; unmapped addresses read zero
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn)
         rdData_r <= 8'h00;
      else if (rdHit)
         rdData_r <= modeValue & READ_MASK;
      else
         rdData_r <= 8'h00;
   end

   // The 20M setting relies on the partner not being an older serializer
   assign rateNxt = rateCode(fast_r, rateSel_r);

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn)
         rate_r <= RATE_5M;
      else
         rate_r <= rateNxt;
   end

   // Errors are expected on the back channel for a while after a change;
   // a remote partner must be in auto-acknowledge before it writes
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         settleCnt_r <= 8'h00;
         settling_r  <= 1'b0;
      end else if (rateNxt != rate_r) begin
         settleCnt_r <= BC_SETTLE_CYC;
         settling_r  <= 1'b1;
      end else if (settleCnt_r != 8'h00) begin
         settleCnt_r <= settleCnt_r - 8'h01;
         settling_r  <= (settleCnt_r != 8'h01);
      end
   end

   // Audio format follows aux codes when automatic, else the manual input
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn)
         audioMode_r <= 2'h0;
      else if (!autoAudio_r)
         audioMode_r <= manualAudioMode;
      else if (auxCodeValid)
         audioMode_r <= auxAudioCode;
   end

   assign bcRate.rate = rate_r;

   bc_rate_divider rateDivider (
      .core_clk (core_clk),
      .resetn   (resetn),
      .bcRate   (bcRate.gen)
   );

   assign regRdData           = rdData_r;
   assign backChannelRate     = rate_r;
   assign backChannelTick     = bcRate.tick;
   assign backChannelSettling = settling_r;
   assign cableCoax           = coax_r;
   assign autoAudioEn         = autoAudio_r;
   assign audioMode           = audioMode_r;
   assign repeaterStrapped    = repeater_r;
   assign strapLoaded         = loaded_r;

   // Checks

   chk_rate_slow: assert property (
      @(posedge core_clk) disable iff (!resetn)
      !fast_r |=> rate_r == ($past(rateSel_r) ? RATE_10M : RATE_5M))
      else $error("slow back-channel rate wrong for select bit");

   chk_rate_fast: assert property (
      @(posedge core_clk) disable iff (!resetn)
      fast_r |=> rate_r == RATE_20M)
      else $error("fast bit did not force the 20M rate");

   chk_settle_window: assert property (
      @(posedge core_clk) disable iff (!resetn)
      (rateNxt != rate_r) |=> settling_r [*8])
      else $error("settling flag too short after a rate change");

   chk_auto_audio: assert property (
      @(posedge core_clk) disable iff (!resetn)
      autoAudio_r && auxCodeValid |=> audioMode_r == $past(auxAudioCode))
      else $error("automatic audio mode did not follow aux code");

   chk_cable_readback: assert property (
      @(posedge core_clk) disable iff (!resetn)
      rdHit |=> rdData_r[BIT_COAX] == $past(coax_r))
      else $error("cable bit read back differs from cable setting");

   chk_strap_load: assert property (
      @(posedge core_clk) disable iff (!resetn)
      $rose(loaded_r) |-> fast_r == $past(strapSync3_r[STRAP_FAST]) &&
                          coax_r == $past(strapSync3_r[STRAP_COAX]))
      else $error("strap values not loaded into fast or cable bit");

   chk_repeater_ro: assert property (
      @(posedge core_clk) disable iff (!resetn)
      loaded_r && $past(loaded_r) |-> $stable(repeater_r))
      else $error("repeater flag changed after strap load");

   chk_reserved_zero: assert property (
      @(posedge core_clk) disable iff (!resetn)
      regRdEn |=> (rdData_r & ~READ_MASK) == 8'h00)
      else $error("reserved bits read as nonzero");

   chk_offset_only: assert property (
      @(posedge core_clk) disable iff (!resetn)
      regRdEn && regAddr != MODE_REG_OFFSET |=> rdData_r == 8'h00)
      else $error("unmapped address returned data");

   chk_read_idle: assert property (
      @(posedge core_clk) disable iff (!resetn)
      !regRdEn |=> rdData_r == 8'h00)
      else $error("read data did not return to zero");

   chk_repeater_write: assert property (
      @(posedge core_clk) disable iff (!resetn)
      wrHit |=> $stable(repeater_r))
      else $error("write changed the repeater flag");

   chk_write_effect: assert property (
      @(posedge core_clk) disable iff (!resetn)
      wrHit |=> rateSel_r == $past(regWrData[BIT_RATE_SEL]) &&
                autoAudio_r == $past(regWrData[BIT_AUTO_AUDIO]))
      else $error("write at the mode offset did not take effect");

   cov_fast_rate: cover property (
      @(posedge core_clk) disable iff (!resetn) rate_r == RATE_20M);

   cov_rate_change: cover property (
      @(posedge core_clk) disable iff (!resetn) $rose(settling_r));

   cov_auto_audio: cover property (
      @(posedge core_clk) disable iff (!resetn) autoAudio_r && auxCodeValid);

   cov_strap_load: cover property (
      @(posedge core_clk) disable iff (!resetn) $rose(loaded_r));

endmodule

//--- hw/rx_link_mode_pkg.sv
// Constants and helpers for the receiver link mode register block.
// Assumes one 40 MHz core clock and an 8-bit register port.
package rx_link_mode_pkg;

   // Register map and field layout
   localparam logic [7:0] MODE_REG_OFFSET = 8'h23;
   localparam int         BIT_RATE_SEL    = 6;
   localparam int         BIT_AUTO_AUDIO  = 5;
   localparam int         BIT_FAST        = 4;
   localparam int         BIT_COAX        = 3;
   localparam int         BIT_REPEATER    = 2;
   localparam logic [7:0] READ_MASK       = 8'h7c;

   // Reset values; fast, coax and repeater are replaced by the strap load
   localparam logic RST_RATE_SEL   = 1'h0;
   localparam logic RST_AUTO_AUDIO = 1'h1;
   localparam logic RST_FAST       = 1'h0;
   localparam logic RST_COAX       = 1'h0;
   localparam logic RST_REPEATER   = 1'h0;

   // Decoded strap options of the first mode-select pin
   localparam int STRAP_COAX     = 0;
   localparam int STRAP_FAST     = 1;
   localparam int STRAP_REPEATER = 2;

   // Back-channel rate codes
   localparam logic [1:0] RATE_5M  = 2'h0;
   localparam logic [1:0] RATE_10M = 2'h1;
   localparam logic [1:0] RATE_20M = 2'h2;

   // Timing
   localparam int CORE_CLK_HZ    = 40_000_000;
   localparam int CORE_PERIOD_NS = 25;
   localparam int BC_5M_HZ       = 5_000_000;
   localparam int BC_10M_HZ      = 10_000_000;
   localparam int BC_20M_HZ      = 20_000_000;
   localparam logic [3:0] DIV_5M  = 4'(CORE_CLK_HZ / BC_5M_HZ);
   localparam logic [3:0] DIV_10M = 4'(CORE_CLK_HZ / BC_10M_HZ);
   localparam logic [3:0] DIV_20M = 4'(CORE_CLK_HZ / BC_20M_HZ);
   localparam int BC_SETTLE_NS  = 2000;
   localparam logic [7:0] BC_SETTLE_CYC =
      8'((BC_SETTLE_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS);
   localparam logic [1:0] STRAP_WAIT_CYC = 2'h3;

   function automatic logic [1:0] rateCode(input logic fast, input logic sel);
      if (fast)
         return RATE_20M;
      return sel ? RATE_10M : RATE_5M;
   endfunction

   function automatic logic [3:0] rateDivisor(input logic [1:0] rate);
      case (rate)
         RATE_20M: return DIV_20M;
         RATE_10M: return DIV_10M;
         default:  return DIV_5M;
      endcase
   endfunction

endpackage

//--- test/serializer_model.sv
// Remote serializer model: sends audio aux codes and keeps its auto-acknowledge state.
// Assumes the receiver's core clock and active-low reset.
module serializer_model #(
   parameter bit OLDER_FAMILY = 1'b0
) (
   input  wire logic       core_clk,
   input  wire logic       resetn,
   input  wire logic       sendReq,
   input  wire logic [1:0] sendCode,
   input  wire logic       slow,
   input  wire logic       autoAckReq,
   output logic            auxCodeValid,
   output logic      [1:0] auxAudioCode,
   output logic            autoAckOn,
   output logic            fastAllowed
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] waitCnt;
   logic       pend;
   logic [1:0] code;
   // Older serializers cannot run the fastest back channel
   assign fastAllowed = !OLDER_FAMILY;
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         {pend, auxCodeValid, waitCnt, code} <= '0;
         auxAudioCode <= 2'h0;
      end else begin
         auxCodeValid <= 1'b0;
         // Code lines change every cycle outside the valid cycle
         auxAudioCode <= ~auxAudioCode;
         if (sendReq) begin
            pend <= 1'b1;
            code <= sendCode;
            waitCnt <= slow ? 3'h6 : 3'h0;
         end else if (pend && waitCnt != 3'h0) begin
            waitCnt <= waitCnt - 3'h1;
         end else if (pend) begin
            pend <= 1'b0;
            auxCodeValid <= 1'b1;
            auxAudioCode <= code;
         end
      end
   end
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         autoAckOn <= 1'b0;
      end else if (autoAckReq) begin
         autoAckOn <= 1'b1;
      end
   end
endmodule

//--- test/tb_receiver_link_mode_register.sv
// Self-checking bench for the receiver link mode register.
// Assumes the design package and the serializer model are compiled first.
module tb_receiver_link_mode_register;
   timeunit 1ns;
   timeprecision 1ps;
   import rx_link_mode_pkg::*;
   logic       core_clk = 0, resetn = 0, regWrEn = 0, regRdEn = 0;
   logic       sendReq = 0, slow = 0, autoAckReq = 0;
   logic [7:0] regAddr = 0, regWrData = 0, regRdData, model;
   logic [2:0] strap = 0;
   logic [1:0] manualAudioMode = 0, sendCode = 0, backChannelRate, audioMode, auxAudioCode;
   logic       backChannelTick, backChannelSettling, cableCoax, autoAudioEn;
   logic       repeaterStrapped, strapLoaded, auxCodeValid, autoAckOn, fastAllowed;
   int         badCount = 0, nChecks = 0, cycles = 0;

   receiver_link_mode_register DUT (.core_clk(core_clk), .resetn(resetn),
      .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
      .regRdData(regRdData), .strapConfigPinOne(strap), .auxCodeValid(auxCodeValid),
      .auxAudioCode(auxAudioCode), .manualAudioMode(manualAudioMode),
      .backChannelRate(backChannelRate), .backChannelTick(backChannelTick),
      .backChannelSettling(backChannelSettling), .cableCoax(cableCoax),
      .autoAudioEn(autoAudioEn), .audioMode(audioMode),
      .repeaterStrapped(repeaterStrapped), .strapLoaded(strapLoaded));
   serializer_model partner (.core_clk(core_clk), .resetn(resetn), .sendReq(sendReq),
      .sendCode(sendCode), .slow(slow), .autoAckReq(autoAckReq),
      .auxCodeValid(auxCodeValid), .auxAudioCode(auxAudioCode),
      .autoAckOn(autoAckOn), .fastAllowed(fastAllowed));

   always #12.5 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 30000) begin
         badCount++;
         closeOut();
      end
   end

   task automatic closeOut();
      $display("Checks %0d mismatches %0d", nChecks, badCount);
      if (badCount == 0 && nChecks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      nChecks++;
      if (got !== exp) begin
         badCount++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   function automatic logic [1:0] expRate(input logic [7:0] v);
      return v[BIT_FAST] ? RATE_20M : (v[BIT_RATE_SEL] ? RATE_10M : RATE_5M);
   endfunction

   function automatic logic [3:0] expDiv(input logic [1:0] r);
      return (r == RATE_20M) ? DIV_20M : ((r == RATE_10M) ? DIV_10M : DIV_5M);
   endfunction

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      regAddr <= a;
      regWrData <= d;
      regWrEn <= 1'b1;
      @(posedge core_clk);
      regWrEn <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge core_clk);
      regAddr <= a;
      regRdEn <= 1'b1;
      @(posedge core_clk);
      regRdEn <= 1'b0;
      #1 d = regRdData;
      @(posedge core_clk);
      #1 check("read idle", 8'h00, regRdData);
   endtask

   task automatic tickGap(output logic [7:0] n);
      int i;
      n = 0;
      // Skip the edge at which a new rate reloads the divider
      @(posedge core_clk) #1;
      for (i = 0; i < 20 && backChannelTick !== 1'b1; i++) @(posedge core_clk) #1;
      do begin
         @(posedge core_clk);
         #1 n++;
      end while (backChannelTick !== 1'b1 && n < 20);
   endtask

   task automatic doReset(input logic [2:0] s);
      logic [7:0] v;
      int         i;
      strap <= s;
      resetn <= 1'b0;
      repeat (3) @(posedge core_clk);
      #1 check("auto audio in reset", 8'h01, {7'h0, autoAudioEn});
      @(posedge core_clk);
      resetn <= 1'b1;
      // Too early: must not survive the strap load
      wr(MODE_REG_OFFSET, 8'hff);
      for (i = 0; i < 10 && strapLoaded !== 1'b1; i++) @(posedge core_clk) #1;
      check("strap loaded", 8'h01, {7'h0, strapLoaded});
      model = {2'b00, 1'b1, s[STRAP_FAST], s[STRAP_COAX], s[STRAP_REPEATER], 2'b00};
      rd(MODE_REG_OFFSET, v);
      check("strap value", model, v);
      check("repeater", {7'h0, s[STRAP_REPEATER]}, {7'h0, repeaterStrapped});
   endtask

   task automatic wrCheck(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] v, n;
      logic [1:0] oldRate;
      oldRate = expRate(model);
      wr(a, d);
      if (a == MODE_REG_OFFSET)
         model = (model & 8'h04) | (d & 8'h78);
      @(posedge core_clk);
      #1 check("rate", {6'h0, expRate(model)}, {6'h0, backChannelRate});
      if (expRate(model) != oldRate)
         check("settling", 8'h01, {7'h0, backChannelSettling});
      check("coax", {7'h0, model[BIT_COAX]}, {7'h0, cableCoax});
      check("auto audio", {7'h0, model[BIT_AUTO_AUDIO]}, {7'h0, autoAudioEn});
      tickGap(n);
      check("tick gap", {4'h0, expDiv(expRate(model))}, n);
      rd(a, v);
      check("readback", (a == MODE_REG_OFFSET) ? model : 8'h00, v);
   endtask

   task automatic audioCheck(input logic [1:0] c);
      int i;
      @(posedge core_clk);
      manualAudioMode <= ~c;
      sendCode <= c;
      slow <= 1'($urandom);
      sendReq <= 1'b1;
      @(posedge core_clk);
      sendReq <= 1'b0;
      for (i = 0; i < 12 && auxCodeValid !== 1'b1; i++) @(posedge core_clk) #1;
      @(posedge core_clk);
      #1 check("audio mode", {6'h0, model[BIT_AUTO_AUDIO] ? c : ~c}, {6'h0, audioMode});
   endtask

   initial begin
      logic [7:0] d, a;
      int         k, p;
      k = $urandom(75783);
      for (p = 0; p < 2; p++) begin
         doReset(p ? ~strap : 3'($urandom));
         @(posedge core_clk);
         autoAckReq <= 1'b1;
         @(posedge core_clk);
         autoAckReq <= 1'b0;
         #1 check("auto ack", 8'h01, {7'h0, autoAckOn});
         wrCheck(MODE_REG_OFFSET, 8'h10);
         wrCheck(MODE_REG_OFFSET, 8'h50);
         wrCheck(MODE_REG_OFFSET, 8'h40);
         wrCheck(MODE_REG_OFFSET, 8'h87);
         wrCheck(8'h22, 8'hff);
         // Settling window: high for exactly 80 cycles after the rate moves
         d = (model ^ 8'h10) & 8'h78;
         wr(MODE_REG_OFFSET, d);
         model = (model & 8'h04) | d;
         @(posedge core_clk);
         #1 check("settle start", 8'h01, {7'h0, backChannelSettling});
         repeat (79) @(posedge core_clk);
         #1 check("settle hold", 8'h01, {7'h0, backChannelSettling});
         @(posedge core_clk);
         #1 check("settle end", 8'h00, {7'h0, backChannelSettling});
         for (k = 0; k < 16; k++) begin
            d = 8'($urandom);
            a = ($urandom % 4 == 0) ? 8'($urandom) : MODE_REG_OFFSET;
            if (!fastAllowed)
               d[BIT_FAST] = 1'b0;
            wrCheck(a, d);
            audioCheck(2'($urandom));
         end
      end
      closeOut();
   end
endmodule
